// ---- include/flash_cmd_regs.vh ----
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// Register block placement and decode
`define FC_BASE_ADDR      32'h40100000
`define FC_BASE_HI        24'h401000
`define FC_OFF_CMD        8'h00
`define FC_OFF_CFG        8'h04
`define FC_OFF_MASKED     8'h08
`define FC_OFF_MASK       8'h0C
`define FC_OFF_RAW        8'h10
`define FC_OFF_SIZE       8'h14
`define FC_OFF_ADDR       8'h18
`define FC_OFF_SIG        8'h24
`define FC_OFF_TRIM_A     8'h28
`define FC_OFF_TRIM_B     8'h2C
`define FC_OFF_TRIM_W     8'h30
`define FC_OFF_WORD0      8'h40
`define FC_OFF_WORD1      8'h44
`define FC_OFF_WORD2      8'h48
`define FC_OFF_WORD3      8'h4C

// Reset values
`define FC_RST_CMD        32'h00000000
`define FC_RST_CFG        32'h00000000
`define FC_RST_MASK       6'h3F
`define FC_RST_ADDR       32'h00000000
`define FC_RST_SIG        32'h0FFFFFFF
`define FC_RST_TRIM_A     32'h0B061515
`define FC_RST_TRIM_B     32'h0B156506
`define FC_RST_TRIM_W     32'h00000011
`define FC_RST_WORD       32'h0FFFFFFF

// Event flag positions
`define FC_EV_DONE        0
`define FC_EV_START       1
`define FC_EV_BUSY        2
`define FC_EV_ILL         3
`define FC_EV_MATCH       4
`define FC_EV_SLEEP       5

// Operation codes
`define FC_CMD_PAGE_ERASE 8'h11
`define FC_CMD_ALL_ERASE  8'h22
`define FC_CMD_PROG_ONE   8'h33
`define FC_CMD_PROG_ALL   8'h44
`define FC_CMD_VERIFY_ALL 8'h55
`define FC_CMD_PROG_MULTI 8'hCC

// Array request kinds
`define FC_ARR_READ       2'h0
`define FC_ARR_PROG       2'h1
`define FC_ARR_ERASE_PG   2'h2
`define FC_ARR_ERASE_ALL  2'h3

// Array geometry and signature
`define FC_LAST_WORD      16'hFFFF
`define FC_PAGE_MASK      16'hFE00
`define FC_SKIP_WORD      32'hFFFFFFFF
`define FC_SIG_SEED       32'hFFFFFFFF
`define FC_SIG_TAPS       32'h8000001B

`endif

// ---- rtl/signature_step.v ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"

module signature_step
(
  input  wire [31:0] i_sig,    // current signature
  input  wire [31:0] i_word,   // word folded in
  output wire [31:0] o_sig     // next signature
);

  // Multiple-input shift register, feedback x32+x31+x4+x3+x1+1
  assign o_sig = {i_sig[30:0], 1'b0}
               ^ ({32{i_sig[31]}} & `FC_SIG_TAPS)
               ^ i_word;

endmodule // signature_step

`default_nettype wire

// ---- rtl/flash_command_controller.v ----
// Functional notes
// - Code 0x11 erases addressed page
// - Code 0x22 erases whole array
// - Code 0x33 programs one addressed word
// - Code 0x44 programs all words alike
// - Code 0x55 reads all, compare or sign
// - Code 0xCC bursts four, skipping all-ones
// - Bit0 done, bit1 started, write-one clears
// - Bit2 set on command while busy
// - Bit3 set on invalid command code when idle
// - Bit4 set when verify fully matched
// - Bit5 set while array is asleep
// - Six-bit mask, resets to all ones
// - Raw flags readable at 0x10
// - Masked flags at 0x08 drive interrupt
// - Program pointer auto-increments per word
// - Size register gives last usable address
// - Signature register holds verify result
// - Erase/program trims reset to documented
// - Wake-up trim resets to 0x11
// - Decode offsets from base 0x40100000
// - Signature polynomial, seeded all ones
// - Burst words at consecutive addresses
// - Started then done flags, cleared by one
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"

module flash_command_controller
(
  input  wire        i_clk,         // system clock, 50 MHz
  input  wire        i_reset,       // async reset, active high
  input  wire        i_wb_cyc,      // bus cycle
  input  wire        i_wb_stb,      // bus strobe
  input  wire        i_wb_we,       // write enable
  input  wire [31:0] i_wb_adr,      // byte address
  input  wire [31:0] i_wb_dat,      // write data
  input  wire [3:0]  i_wb_sel,      // byte lanes
  output reg  [31:0] o_wb_dat,      // read data
  output wire        o_wb_ack,      // acknowledge
  output wire        o_irq,         // interrupt request
  output wire        o_arr_req,     // array request, held to ack
  output reg  [1:0]  o_arr_kind,    // array request kind
  output reg  [15:0] o_arr_addr,    // array word address
  output wire [31:0] o_arr_wdata,   // array program data
  output wire [31:0] o_trim_a,      // erase/program timing
  output wire [31:0] o_trim_b,      // erase/program timing
  output wire [31:0] o_trim_w,      // wake-up timing
  output wire [31:0] o_cfg,         // wrapper setup
  input  wire        i_arr_ack,     // array step finished, pulse
  input  wire [31:0] i_arr_rdata,   // array read data with ack
  input  wire        i_arr_asleep   // array not ready
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg         ack_ff;
  reg         state_ff;
  reg  [7:0]  op_ff;
  reg  [16:0] cnt_ff;
  reg  [1:0]  slot_ff;
  reg         match_ff;
  reg  [31:0] cmd_ff;
  reg  [31:0] cfg_ff;
  reg  [5:0]  mask_ff;
  reg  [5:0]  raw_ff;
  reg  [31:0] addr_ff;
  reg  [31:0] sig_ff;
  reg  [31:0] trim_a_ff;
  reg  [31:0] trim_b_ff;
  reg  [31:0] trim_w_ff;
  reg  [31:0] word_ff [0:3];

  wire        hit;
  wire [7:0]  off;
  wire        wr;
  wire        busy;
  wire        cmd_wr;
  wire        code_ok;
  wire        is_mass;
  wire        is_burst;
  wire        skip;
  wire        step;
  wire        last;
  wire [31:0] sig_next;
  wire [31:0] wmask;
  reg  [5:0]  ev_set;
  reg  [5:0]  ev_clr;
  reg  [31:0] rd_val;
  integer     i;

  // Register decode above the base
  // base address decode
  assign hit = i_wb_adr[31:8] == `FC_BASE_HI;
  assign off = i_wb_adr[7:0];

  // Ack one cycle after the request; writes land on the acked edge
  assign o_wb_ack = ack_ff;
  assign wr       = i_wb_cyc & i_wb_stb & i_wb_we & ack_ff & hit;
  assign wmask    = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                     {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  assign busy     = (state_ff == ST_RUN);
  assign cmd_wr   = wr & (off == `FC_OFF_CMD) & i_wb_sel[0];
  assign code_ok  = (i_wb_dat[31:8] == 24'h000000) &
                    ((i_wb_dat[7:0] == `FC_CMD_PAGE_ERASE) |
                     (i_wb_dat[7:0] == `FC_CMD_ALL_ERASE)  |
                     (i_wb_dat[7:0] == `FC_CMD_PROG_ONE)   |
                     (i_wb_dat[7:0] == `FC_CMD_PROG_ALL)   |
                     (i_wb_dat[7:0] == `FC_CMD_VERIFY_ALL) |
                     (i_wb_dat[7:0] == `FC_CMD_PROG_MULTI));

  assign is_mass  = (op_ff == `FC_CMD_PROG_ALL) |
                    (op_ff == `FC_CMD_VERIFY_ALL);
  assign is_burst = (op_ff == `FC_CMD_PROG_MULTI);
  // all-ones burst words are not programmed
  assign skip     = busy & is_burst & (word_ff[slot_ff] == `FC_SKIP_WORD);
  assign step     = busy & (skip | i_arr_ack);
  assign last     = is_mass ? (cnt_ff[15:0] == `FC_LAST_WORD) :
                    is_burst ? (slot_ff == 2'h3) : 1'b1;
  assign o_arr_req = busy & ~skip;

  // program data is the same word for the whole array
  // The slot counter also wraps during mass steps, so only bursts use it
  assign o_arr_wdata = is_burst ? word_ff[slot_ff] : word_ff[0];
  assign o_trim_a    = trim_a_ff;
  assign o_trim_b    = trim_b_ff;
  assign o_trim_w    = trim_w_ff;
  assign o_cfg       = cfg_ff;

  signature_step u_sig
  (
    .i_sig  (sig_ff),
    .i_word (i_arr_rdata),
    .o_sig  (sig_next)
  );

  // Array request kind and address
  always @*
  begin
    o_arr_kind = `FC_ARR_PROG;
    o_arr_addr = addr_ff[15:0];
    case (op_ff)
      // page address, row and word bits forced to zero
      `FC_CMD_PAGE_ERASE:
      begin
        o_arr_kind = `FC_ARR_ERASE_PG;
        o_arr_addr = addr_ff[15:0] & `FC_PAGE_MASK;
      end
      `FC_CMD_ALL_ERASE:
        o_arr_kind = `FC_ARR_ERASE_ALL;
      `FC_CMD_VERIFY_ALL:
      begin
        o_arr_kind = `FC_ARR_READ;
        o_arr_addr = cnt_ff[15:0];
      end
      `FC_CMD_PROG_ALL:
        o_arr_addr = cnt_ff[15:0];
      default:
        o_arr_kind = `FC_ARR_PROG;
    endcase
  end

  // Event sources and write-one clears
  always @*
  begin
    ev_set = 6'h00;
    ev_clr = 6'h00;
    // started flag when a command is taken
    ev_set[`FC_EV_START] = cmd_wr & ~busy & code_ok;
    ev_set[`FC_EV_DONE]  = step & last;
    ev_set[`FC_EV_BUSY]  = cmd_wr & busy;
    ev_set[`FC_EV_ILL]   = cmd_wr & ~busy & ~code_ok;
    // whole verify matched, including the last word
    ev_set[`FC_EV_MATCH] = step & last & (op_ff == `FC_CMD_VERIFY_ALL) &
                           match_ff & (i_arr_rdata == word_ff[0]);
    ev_set[`FC_EV_SLEEP] = i_arr_asleep;
    if (wr & i_wb_sel[0] &
        ((off == `FC_OFF_MASKED) | (off == `FC_OFF_RAW)))
    begin
      ev_clr = i_wb_dat[5:0];
    end
  end

  // Read mux
  always @*
  begin
    rd_val = 32'h00000000;
    case (off)
      `FC_OFF_CMD:    rd_val = cmd_ff;
      `FC_OFF_CFG:    rd_val = cfg_ff;
      `FC_OFF_MASKED: rd_val = {26'h0000000, raw_ff & mask_ff};
      `FC_OFF_MASK:   rd_val = {26'h0000000, mask_ff};
      `FC_OFF_RAW:    rd_val = {26'h0000000, raw_ff};
      `FC_OFF_SIZE:   rd_val = {16'h0000, `FC_LAST_WORD};
      `FC_OFF_ADDR:   rd_val = addr_ff;
      `FC_OFF_SIG:    rd_val = sig_ff;
      `FC_OFF_TRIM_A: rd_val = trim_a_ff;
      `FC_OFF_TRIM_B: rd_val = trim_b_ff;
      `FC_OFF_TRIM_W: rd_val = trim_w_ff;
      `FC_OFF_WORD0:  rd_val = word_ff[0];
      `FC_OFF_WORD1:  rd_val = word_ff[1];
      `FC_OFF_WORD2:  rd_val = word_ff[2];
      `FC_OFF_WORD3:  rd_val = word_ff[3];
      default:        rd_val = 32'h00000000;
    endcase
    if (!hit)
    begin
      rd_val = 32'h00000000;
    end
  end

  assign o_irq = |(raw_ff & mask_ff);

  // Bus slave timing
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ack_ff   <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      ack_ff <= i_wb_cyc & i_wb_stb & ~ack_ff;
      if (i_wb_cyc & i_wb_stb & ~ack_ff)
      begin
        o_wb_dat <= rd_val;
      end
    end
  end

  // Flags: a set in the clearing cycle wins
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      raw_ff <= 6'h00;
    end
    else
    begin
      raw_ff <= (raw_ff & ~ev_clr) | ev_set;
    end
  end

  // Software registers
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cmd_ff    <= `FC_RST_CMD;
      cfg_ff    <= `FC_RST_CFG;
      mask_ff   <= `FC_RST_MASK;
      trim_a_ff <= `FC_RST_TRIM_A;
      trim_b_ff <= `FC_RST_TRIM_B;
      trim_w_ff <= `FC_RST_TRIM_W;
      for (i = 0; i < 4; i = i + 1)
      begin
        word_ff[i] <= `FC_RST_WORD;
      end
    end
    else if (wr)
    begin
      case (off)
        `FC_OFF_CMD:
          cmd_ff <= (cmd_ff & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_CFG:
          cfg_ff <= (cfg_ff & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_MASK:
          if (i_wb_sel[0])
          begin
            mask_ff <= i_wb_dat[5:0];
          end
        `FC_OFF_TRIM_A:
          trim_a_ff <= (trim_a_ff & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_TRIM_B:
          trim_b_ff <= (trim_b_ff & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_TRIM_W:
          trim_w_ff <= (trim_w_ff & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_WORD0:
          word_ff[0] <= (word_ff[0] & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_WORD1:
          word_ff[1] <= (word_ff[1] & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_WORD2:
          word_ff[2] <= (word_ff[2] & ~wmask) | (i_wb_dat & wmask);
        `FC_OFF_WORD3:
          word_ff[3] <= (word_ff[3] & ~wmask) | (i_wb_dat & wmask);
        default:
          cmd_ff <= cmd_ff;
      endcase
    end
  end

  // Program pointer: hardware advance beats a software write
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      addr_ff <= `FC_RST_ADDR;
    end
    else if (step & ((op_ff == `FC_CMD_PROG_ONE) | is_burst))
    begin
      addr_ff <= addr_ff + 32'h00000001;
    end
    else if (wr & (off == `FC_OFF_ADDR))
    begin
      addr_ff <= (addr_ff & ~wmask) | (i_wb_dat & wmask);
    end
  end

  // Sequencer
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_ff <= ST_IDLE;
      op_ff    <= 8'h00;
      cnt_ff   <= 17'h00000;
      slot_ff  <= 2'h0;
      match_ff <= 1'b0;
      sig_ff   <= `FC_RST_SIG;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          // busy or invalid codes start nothing
          if (cmd_wr & code_ok)
          begin
            // single program begins at the pointer
            state_ff <= ST_RUN;
            op_ff    <= i_wb_dat[7:0];
            cnt_ff   <= 17'h00000;
            slot_ff  <= 2'h0;
            match_ff <= 1'b1;
            if (i_wb_dat[7:0] == `FC_CMD_VERIFY_ALL)
            begin
              sig_ff <= `FC_SIG_SEED;
            end
          end
        ST_RUN:
          if (step)
          begin
            if (op_ff == `FC_CMD_VERIFY_ALL)
            begin
              sig_ff <= sig_next;
              if (i_arr_rdata != word_ff[0])
              begin
                match_ff <= 1'b0;
              end
            end
            if (last)
            begin
              state_ff <= ST_IDLE;
            end
            cnt_ff  <= cnt_ff + 17'h00001;
            slot_ff <= slot_ff + 2'h1;
          end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // flash_command_controller

`default_nettype wire

// ---- tb/flash_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
(
  input  wire logic        i_clk,   // clock
  input  wire logic        i_reset, // reset
  input  wire logic        i_req,   // step request
  input  wire logic [1:0]  i_kind,  // step kind
  input  wire logic [15:0] i_addr,  // word address
  input  wire logic [31:0] i_wdata, // program data
  input  wire logic [7:0]  i_dly,   // answer delay
  output logic             o_ack,   // step done
  output logic [31:0]      o_rdata, // read data
  output logic [31:0]      o_cnt,   // steps done
  output logic [1:0]       o_kind,  // last kind
  output logic [15:0]      o_addr,  // last address
  output logic [31:0]      o_data   // last data
);
  logic [7:0] wait_ff;
  // Off the ack the read bus shows junk, never the last word
  assign o_rdata = o_ack ? 32'hFFFFFFFF : ~o_data ^ {4{wait_ff}};
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wait_ff <= 8'h00;
      o_ack <= 1'b0;
      o_cnt <= 32'h0;
      o_kind <= 2'h0;
      o_addr <= 16'h0;
      o_data <= 32'h0;
    end
    else if (i_req && !o_ack && wait_ff >= i_dly)
    begin
      wait_ff <= 8'h00;
      o_ack <= 1'b1;
      o_cnt <= o_cnt + 32'h1;
      o_kind <= i_kind;
      o_addr <= i_addr;
      o_data <= i_wdata;
    end
    else
    begin
      o_ack <= 1'b0;
      wait_ff <= (i_req && !o_ack) ? wait_ff + 8'h01 : 8'h00;
    end
  end
endmodule // flash_array_model
`default_nettype wire

// ---- tb/flash_command_controller_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"
module flash_command_controller_properties
(
  input wire logic        i_clk,        // clock
  input wire logic        i_reset,      // reset
  input wire logic        i_wb_cyc,     // cycle
  input wire logic        i_wb_stb,     // strobe
  input wire logic        i_wb_we,      // write
  input wire logic [31:0] i_wb_adr,     // address
  input wire logic [31:0] i_wb_dat,     // wr data
  input wire logic [3:0]  i_wb_sel,     // lanes
  input wire logic [31:0] o_wb_dat,     // rd data
  input wire logic        o_wb_ack,     // ack
  input wire logic        o_irq,        // irq
  input wire logic        o_arr_req,    // array req
  input wire logic [1:0]  o_arr_kind,   // kind
  input wire logic [15:0] o_arr_addr,   // address
  input wire logic [31:0] o_arr_wdata,  // data
  input wire logic [31:0] o_trim_a,     // trim
  input wire logic [31:0] o_trim_b,     // trim
  input wire logic [31:0] o_trim_w,     // trim
  input wire logic [31:0] o_cfg,        // setup
  input wire logic        i_arr_ack,    // step done
  input wire logic [31:0] i_arr_rdata,  // rd data
  input wire logic        i_arr_asleep  // asleep
);
  logic [5:0] mask_ff;
  logic       bus_rd;
  logic       mask_wr;
  assign bus_rd = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
  assign mask_wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack &&
                   i_wb_sel[0] && i_wb_adr == 32'h4010000C;
  // Shadow of the mask so the irq can be judged from the ports
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      mask_ff <= 6'h3F;
    else if (mask_wr)
      mask_ff <= i_wb_dat[5:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_ack;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_out;
    bus_rd && i_wb_adr[31:8] != 24'h401000 |=> o_wb_dat == 32'h0;
  endproperty
  a_out: assert property (p_out) else $error("outside");
  property p_resv;
    bus_rd && i_wb_adr inside {32'h40100008, 32'h4010000C, 32'h40100010}
    |=> o_wb_dat[31:6] == 26'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("resv");
  property p_size;
    bus_rd && i_wb_adr == 32'h40100014 |=> o_wb_dat == 32'h0000FFFF;
  endproperty
  a_size: assert property (p_size) else $error("size");
  property p_hold;
    o_arr_req && !i_arr_ack |=> o_arr_req;
  endproperty
  a_hold: assert property (p_hold) else $error("req drop");
  property p_steady;
    o_arr_req && !i_arr_ack |=> $stable(o_arr_addr) && $stable(o_arr_wdata);
  endproperty
  a_steady: assert property (p_steady) else $error("req moved");
  property p_page;
    o_arr_req && o_arr_kind == 2'h2 |-> o_arr_addr[8:0] == 9'h000;
  endproperty
  a_page: assert property (p_page) else $error("page addr");
  property p_sleep;
    i_arr_asleep && mask_ff[5] && !mask_wr |=> o_irq;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep irq");
  property p_quiet;
    mask_ff == 6'h00 |-> !o_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("masked irq");
  c_erase: cover property (o_arr_req && o_arr_kind == 2'h3);
  c_prog: cover property (i_arr_ack && o_arr_kind == 2'h1);
  c_irq: cover property (o_irq ##1 !o_irq);
endmodule // flash_command_controller_properties
bind flash_command_controller flash_command_controller_properties u_prop (.*);
`default_nettype wire

// ---- tb/flash_command_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_command_controller_tb;
  logic        i_clk, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, i_arr_asleep;
  logic        o_wb_ack, o_irq, o_arr_req, i_arr_ack;
  logic [3:0]  i_wb_sel;
  logic [1:0]  o_arr_kind, m_kind;
  logic [15:0] o_arr_addr, m_addr;
  logic [7:0]  dly;
  logic [31:0] i_wb_adr, i_wb_dat, o_wb_dat, o_arr_wdata, o_trim_a;
  logic [31:0] o_trim_b, o_trim_w, o_cfg, i_arr_rdata, m_cnt, m_data;
  int          n_mismatch, num_checks;
  localparam logic [7:0] offs [10] = '{8'h0C, 8'h28, 8'h2C, 8'h30,
    8'h14, 8'h18, 8'h10, 8'h24, 8'h40, 8'h34};
  localparam logic [31:0] vals [10] = '{32'h3F, 32'h0B061515,
    32'h0B156506, 32'h11, 32'hFFFF, 32'h0, 32'h0, 32'h0FFFFFFF,
    32'h0FFFFFFF, 32'h0};

  flash_command_controller DUT (.*);
  flash_array_model u_arr
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_req   (o_arr_req),
    .i_kind  (o_arr_kind),
    .i_addr  (o_arr_addr),
    .i_wdata (o_arr_wdata),
    .i_dly   (dly),
    .o_ack   (i_arr_ack),
    .o_rdata (i_arr_rdata),
    .o_cnt   (m_cnt),
    .o_kind  (m_kind),
    .o_addr  (m_addr),
    .o_data  (m_data)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  end
  endtask

  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [31:0] d, output logic [31:0] q);
  begin
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    @(posedge i_clk);
    while (o_wb_ack !== 1'b1)
      @(posedge i_clk);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  end
  endtask

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, {24'h401000, o}, d, q);
  endtask

  task automatic chr(input logic [7:0] o, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, {24'h401000, o}, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wait_flag(input int b);
    logic [31:0] q;
  begin
    q = 32'h0;
    while (q[b] !== 1'b1)
      wb(1'b0, 32'h40100010, 32'h0, q);
  end
  endtask

  task automatic t_reset;
    logic [31:0] q;
  begin
    chk(o_trim_a, 32'h0B061515);
    chk(o_trim_b, 32'h0B156506);
    chk(o_trim_w, 32'h00000011);
    wr(8'h14, 32'h0);
    for (int i = 0; i < 10; i++)
      chr(offs[i], vals[i]);
    wb(1'b0, 32'h40200008, 32'h0, q);
    chk(q, 32'h0);
    wr(8'h30, 32'h00000022);
    chk(o_trim_w, 32'h00000022);
    wr(8'h04, 32'h5A5AA5A5);
    chk(o_cfg, 32'h5A5AA5A5);
  end
  endtask

  task automatic rst;
  begin
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chr(8'h18, 32'h0);
    chr(8'h24, 32'h0FFFFFFF);
  end
  endtask

  // Mass steps outlast the run, so each one is cut short by a reset
  task automatic t_mass;
    logic [31:0] c;
  begin
    c = m_cnt;
    wr(8'h40, 32'h12345678);
    wr(8'h44, 32'h0000FFFF);
    wr(8'h00, 32'h00000044);
    repeat (20) @(posedge i_clk);
    chk({30'h0, m_kind}, 32'h1);
    chk(m_data, 32'h12345678);
    chk({16'h0, m_addr}, m_cnt - c - 32'h1);
    rst;
    dly <= 8'd40;
    wr(8'h40, 32'hFFFFFFFF);
    wr(8'h00, 32'h00000055);
    chr(8'h24, 32'hFFFFFFFF);
    c = m_cnt;
    while (m_cnt == c)
      @(posedge i_clk);
    repeat (3) @(posedge i_clk);
    // One all-ones word folded into the all-ones seed
    chr(8'h24, 32'h8000001A);
    chk({30'h0, m_kind}, 32'h0);
    chk({16'h0, m_addr}, 32'h0);
    wr(8'h00, 32'h00000044);
    chr(8'h10, 32'h00000006);
    rst;
    dly <= 8'd0;
  end
  endtask

  task automatic t_prog;
    logic [31:0] c;
  begin
    c = m_cnt;
    wr(8'h18, 32'h00000100);
    wr(8'h40, 32'hA5A50F0F);
    wr(8'h00, 32'h00000033);
    wait_flag(1);
    wr(8'h08, 32'h00000002);
    wait_flag(0);
    chk(m_cnt, c + 32'h1);
    chk({16'h0, m_addr}, 32'h00000100);
    chk(m_data, 32'hA5A50F0F);
    chr(8'h18, 32'h00000101);
    wr(8'h08, 32'h00000001);
    chr(8'h10, 32'h0);
  end
  endtask

  task automatic t_burst;
    logic [31:0] c;
  begin
    c = m_cnt;
    wr(8'h18, 32'h000001F0);
    wr(8'h40, 32'h11111110);
    wr(8'h44, 32'hFFFFFFFF);
    wr(8'h48, 32'h22222220);
    wr(8'h4C, 32'h33333330);
    wr(8'h00, 32'h000000CC);
    wait_flag(0);
    chk(m_cnt, c + 32'h3);
    chk({16'h0, m_addr}, 32'h000001F3);
    chk(m_data, 32'h33333330);
    chr(8'h18, 32'h000001F4);
    wr(8'h10, 32'h0000003F);
  end
  endtask

  task automatic t_busy;
    logic [31:0] c;
  begin
    dly <= 8'd40;
    c = m_cnt;
    wr(8'h18, 32'h00000345);
    wr(8'h00, 32'h00000011);
    wr(8'h00, 32'h00000022);
    chr(8'h10, 32'h00000006);
    wait_flag(0);
    chk(m_cnt, c + 32'h1);
    chk({30'h0, m_kind}, 32'h2);
    chk({16'h0, m_addr}, 32'h00000200);
    wr(8'h10, 32'h0000003F);
    chk({31'h0, o_arr_req}, 32'h0);
    wr(8'h00, 32'h00000022);
    wait_flag(0);
    chk({30'h0, m_kind}, 32'h3);
    dly <= 8'd0;
    wr(8'h10, 32'h0000003F);
  end
  endtask

  task automatic t_ill;
    logic [31:0] c;
  begin
    c = m_cnt;
    wr(8'h00, 32'h00000077);
    chr(8'h10, 32'h00000008);
    chk(m_cnt, c);
  end
  endtask

  task automatic t_mask;
  begin
    wr(8'h0C, 32'h0);
    chr(8'h08, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    chr(8'h10, 32'h00000008);
    wr(8'h0C, 32'h0000003F);
    chr(8'h08, 32'h00000008);
    chk({31'h0, o_irq}, 32'h1);
    wr(8'h08, 32'h00000008);
    chr(8'h10, 32'h0);
  end
  endtask

  task automatic t_sleep;
  begin
    i_arr_asleep <= 1'b1;
    @(posedge i_clk);
    i_arr_asleep <= 1'b0;
    chr(8'h10, 32'h00000020);
    chk({31'h0, o_irq}, 32'h1);
    wr(8'h10, 32'h00000020);
    chr(8'h10, 32'h0);
  end
  endtask

  task automatic results;
  begin
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    i_reset = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 32'h0;
    i_wb_dat = 32'h0;
    i_wb_sel = 4'hF;
    i_arr_asleep = 1'b0;
    dly = 8'd0;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset;
    t_busy;
    t_prog;
    t_burst;
    t_ill;
    t_mask;
    t_sleep;
    t_mass;
    results;
  end

  // Whole run needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    results;
  end
endmodule // flash_command_controller_tb
`default_nettype wire
